/* logic/lpc_clock_output_gating.sv */
// Contract
// - pin1_stoppable lets CLKRUN# stop pin b
// - pin0_stoppable lets CLKRUN# stop pin a
// - pin1_output_enable low holds pin b low
// - pin0_output_enable low holds pin a low
// - lock bits are sticky and freeze settings
// - lock bit 4 freezes global stop enable
// - lock bit 3 freezes pin b stoppable
// - lock bit 2 freezes pin a stoppable
// - lock bit 1 freezes pin b enable
// - lock bit 0 freezes pin a enable
// - global enable gates any clock stopping
// - idle delay counted from CLKRUN# rising
// - zero gives minimum, each unit adds four
`timescale 1ns/1ps
`default_nettype none
module lpc_clock_output_gating
	import clk_gate_pkg::*;
(
	input  wire logic       i_ref_clk,      // 50 MHz system clock
	input  wire logic       i_sys_rst,      // async platform reset, high
	input  wire logic       i_clk_en,       // freezes all state when low
	input  wire logic       i_cfg_sel,      // portal selects this region
	input  wire logic [7:0] i_cfg_index,    // register index
	input  wire logic       i_cfg_wr,       // write strobe, one cycle
	input  wire logic       i_cfg_rd,       // read strobe, one cycle
	input  wire logic [7:0] i_cfg_wdata,    // write data
	output logic      [7:0] o_cfg_rdata,    // read data, registered
	input  wire logic       i_bus_req,      // bridge wants an LPC cycle
	output logic            o_bus_grant,    // clocks running, cycle may go
	input  wire logic       i_clkrun_n,     // CLKRUN# pin level
	output logic            o_clkrun_n,     // CLKRUN# drive value
	output logic            o_clkrun_oe,    // CLKRUN# drive enable
	output logic            o_bus_clock_out_a, // first bus clock pin
	output logic            o_bus_clock_out_b, // second bus clock pin
	output logic            o_clocks_stopped   // stop state, status
);
	typedef struct packed {
		logic        pin1_stoppable;      // pin b may be stopped
		logic        pin0_stoppable;      // pin a may be stopped
		logic        pin1_output_enable;  // pin b may toggle
		logic        pin0_output_enable;  // pin a may toggle
		logic        stop_feature_lock;   // freezes global enable
		logic        pin1_stoppable_lock; // freezes pin b stoppable
		logic        pin0_stoppable_lock; // freezes pin a stoppable
		logic        pin1_output_lock;    // freezes pin b enable
		logic        pin0_output_lock;    // freezes pin a enable
		logic        stop_feature_enable; // global stop enable
		logic [5:0]  idle_field;          // idle delay units
		logic [7:0]  rdata;               // read data holding
		logic        clkrun_s1;           // synchroniser stage one
		logic        clkrun_s2;           // synchroniser stage two
		logic        clkrun_prev;         // previous synced level
		stop_state_t state;               // stop sequencer
		logic        div;                 // bus clock phase
		logic        clk_a;               // pin a output
		logic        clk_b;               // pin b output
		logic        drive_low;           // pulling CLKRUN# low
	} gate_t;

	gate_t st_r;   // registered state
	gate_t st_nxt; // next state

	logic                  wr_hit;     // write into this region
	logic                  tick;       // one bus clock completes
	logic                  clk_rose;   // CLKRUN# released by all
	logic                  timer_start; // begin idle wait
	logic                  timer_abort; // cancel idle wait
	logic                  timer_done;  // idle wait expired
	logic [IDLE_CNT_W-1:0] idle_load;   // clocks to wait
	logic                  gate_a;      // pin a silenced
	logic                  gate_b;      // pin b silenced

	// idle wait in bus clocks for a field value
	// zero units gives the base figure, the shortest wait allowed;
	// each further unit adds a fixed step of bus clocks.
	// the product is cut to the counter width on purpose: the largest
	// field value still fits in the nine-bit counter.
	function automatic logic [IDLE_CNT_W-1:0] idle_clocks(input logic [5:0] units);
		logic [IDLE_CNT_W-1:0] ext;
		ext         = {3'h0, units};
		idle_clocks = IDLE_BASE_CLKS + IDLE_CNT_W'(ext * IDLE_STEP_CLKS);
	endfunction

	// read view of one register, reserved bits zero
	// unmapped indexes of the region also read as zero, so software
	// probing the reserved slots never sees stale bits.
	function automatic logic [7:0] reg_view(input gate_t s, input logic [7:0] idx);
		case (idx)
			IDX_OUTPUT_ENABLES: reg_view = {4'h0, s.pin1_stoppable, s.pin0_stoppable,
				s.pin1_output_enable, s.pin0_output_enable};
			IDX_SETTING_LOCKS:  reg_view = {3'h0, s.stop_feature_lock,
				s.pin1_stoppable_lock, s.pin0_stoppable_lock,
				s.pin1_output_lock, s.pin0_output_lock};
			IDX_STOP_CONTROL:   reg_view = {7'h00, s.stop_feature_enable};
			IDX_IDLE_DELAY:     reg_view = {s.idle_field, 2'h0};
			default:            reg_view = 8'h00;
		endcase
	endfunction

	// a write only counts while the portal points into this region
	assign wr_hit    = i_cfg_wr && i_cfg_sel;
	// the divider low phase marks the end of one bus clock
	assign tick      = !st_r.div;
	assign clk_rose  = st_r.clkrun_s2 && !st_r.clkrun_prev;
	assign idle_load = idle_clocks(st_r.idle_field);

	// stopping only bites when the pin is stoppable and feature on
	assign gate_a = (st_r.state == ST_STOPPED) && st_r.stop_feature_enable
		&& st_r.pin0_stoppable;
	assign gate_b = (st_r.state == ST_STOPPED) && st_r.stop_feature_enable
		&& st_r.pin1_stoppable;

	// all register, handshake and clock logic
	// hazard: the line is shared and may be driven by any peripheral,
	// so its level is only trusted after the two-stage synchroniser.
	// the sequencer never stops a clock while a request is pending.
	always_comb
	begin
		st_nxt      = st_r;
		timer_start = 1'b0;
		timer_abort = 1'b0;

		// pin sampled through two stages; only stage two is read
		st_nxt.clkrun_s1   = i_clkrun_n;
		st_nxt.clkrun_s2   = st_r.clkrun_s1;
		st_nxt.clkrun_prev = st_r.clkrun_s2;

		// register writes; a field obeys the lock held before this write
		if (wr_hit)
		begin
			case (i_cfg_index)
				IDX_OUTPUT_ENABLES:
				begin
					if (!st_r.pin1_stoppable_lock)
						st_nxt.pin1_stoppable = i_cfg_wdata[POS_PIN1_STOPPABLE];
					if (!st_r.pin0_stoppable_lock)
						st_nxt.pin0_stoppable = i_cfg_wdata[POS_PIN0_STOPPABLE];
					if (!st_r.pin1_output_lock)
						st_nxt.pin1_output_enable = i_cfg_wdata[POS_PIN1_OUT_EN];
					if (!st_r.pin0_output_lock)
						st_nxt.pin0_output_enable = i_cfg_wdata[POS_PIN0_OUT_EN];
				end
				IDX_SETTING_LOCKS:
				begin
					// ones set, zeros never clear
					st_nxt.stop_feature_lock = st_r.stop_feature_lock
						| i_cfg_wdata[POS_STOP_FEATURE_LOCK];
					st_nxt.pin1_stoppable_lock = st_r.pin1_stoppable_lock
						| i_cfg_wdata[POS_PIN1_STOP_LOCK];
					st_nxt.pin0_stoppable_lock = st_r.pin0_stoppable_lock
						| i_cfg_wdata[POS_PIN0_STOP_LOCK];
					st_nxt.pin1_output_lock = st_r.pin1_output_lock
						| i_cfg_wdata[POS_PIN1_OUT_LOCK];
					st_nxt.pin0_output_lock = st_r.pin0_output_lock
						| i_cfg_wdata[POS_PIN0_OUT_LOCK];
				end
				IDX_STOP_CONTROL:
				begin
					if (!st_r.stop_feature_lock)
						st_nxt.stop_feature_enable = i_cfg_wdata[POS_STOP_FEATURE_EN];
				end
				IDX_IDLE_DELAY:
				begin
					st_nxt.idle_field = i_cfg_wdata[POS_IDLE_LSB +: IDLE_FIELD_W];
				end
				default:
				begin
					// reserved and foreign indexes ignore writes
					st_nxt.rdata = st_r.rdata;
				end
			endcase
		end

		// read data captured on the strobe, zero when not selected
		if (i_cfg_rd)
			st_nxt.rdata = i_cfg_sel ? reg_view(st_r, i_cfg_index) : 8'h00;

		// bus clock divider runs always; pins gated on the low phase
		// gating on the low phase keeps every pin pulse full width,
		// so a stop or restart never leaves a runt high level.
		st_nxt.div = !st_r.div;

		// clock-stop sequencer
		case (st_r.state)
			ST_RUN:
			begin
				st_nxt.drive_low = 1'b0;
				// CLKRUN# released by every agent starts the idle wait
				if (st_r.stop_feature_enable && clk_rose && !i_bus_req)
				begin
					timer_start  = 1'b1;
					st_nxt.state = ST_IDLE_WAIT;
				end
			end
			ST_IDLE_WAIT:
			begin
				// any request or a disabled feature cancels the stop
				if (!st_r.clkrun_s2 || i_bus_req || !st_r.stop_feature_enable)
				begin
					timer_abort  = 1'b1;
					st_nxt.state = ST_RUN;
				end
				else if (timer_done)
				begin
					timer_abort  = 1'b1;
					st_nxt.state = ST_STOPPED;
				end
			end
			ST_STOPPED:
			begin
				// feature switched off brings clocks straight back
				if (!st_r.stop_feature_enable)
					st_nxt.state = ST_RUN;
				else if (i_bus_req)
				begin
					st_nxt.drive_low = 1'b1;
					st_nxt.state     = ST_RESTART;
				end
				else if (!st_r.clkrun_s2)
					st_nxt.state = ST_RESTART;
			end
			ST_RESTART:
			begin
				// clocks toggle again; grant once the next divider low phase returns to run
				if (tick)
				begin
					st_nxt.drive_low = 1'b0;
					st_nxt.state     = ST_RUN;
				end
			end
			default:
			begin
				st_nxt.state = ST_RUN;
			end
		endcase

		// pins follow the divider only while enabled and not stopped
		// a disabled pin stays low whatever the sequencer does;
		// a pin that is not stoppable keeps running through a stop.
		st_nxt.clk_a = st_nxt.div && st_r.pin0_output_enable && !gate_a;
		st_nxt.clk_b = st_nxt.div && st_r.pin1_output_enable && !gate_b;
	end

	// state register; every field returns to its default on reset
	always_ff @(posedge i_ref_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			st_r                     <= '0;
			st_r.pin1_stoppable      <= RST_OUTPUT_ENABLES[POS_PIN1_STOPPABLE];
			st_r.pin0_stoppable      <= RST_OUTPUT_ENABLES[POS_PIN0_STOPPABLE];
			st_r.pin1_output_enable  <= RST_OUTPUT_ENABLES[POS_PIN1_OUT_EN];
			st_r.pin0_output_enable  <= RST_OUTPUT_ENABLES[POS_PIN0_OUT_EN];
			st_r.stop_feature_lock   <= RST_SETTING_LOCKS[POS_STOP_FEATURE_LOCK];
			st_r.pin1_stoppable_lock <= RST_SETTING_LOCKS[POS_PIN1_STOP_LOCK];
			st_r.pin0_stoppable_lock <= RST_SETTING_LOCKS[POS_PIN0_STOP_LOCK];
			st_r.pin1_output_lock    <= RST_SETTING_LOCKS[POS_PIN1_OUT_LOCK];
			st_r.pin0_output_lock    <= RST_SETTING_LOCKS[POS_PIN0_OUT_LOCK];
			st_r.stop_feature_enable <= RST_STOP_FEATURE;
			st_r.idle_field          <= RST_IDLE_FIELD;
			st_r.clkrun_s1           <= 1'b1;
			st_r.clkrun_s2           <= 1'b1;
			st_r.clkrun_prev         <= 1'b1;
			st_r.state               <= ST_RUN;
		end
		else if (i_clk_en)
			st_r <= st_nxt;
	end

	// idle wait counter in bus clocks
	// the timer shares the clock enable, so a frozen block also
	// freezes the idle wait instead of letting it run out early.
	idle_delay_timer idle_delay_timer_inst (
		.i_ref_clk (i_ref_clk),
		.i_sys_rst (i_sys_rst),
		.i_clk_en  (i_clk_en),
		.i_tick    (tick),
		.i_start   (timer_start),
		.i_abort   (timer_abort),
		.i_load    (idle_load),
		.o_done    (timer_done)
	);

	// outputs; CLKRUN# is open drain, only ever pulled low
	// the grant is combinational so a request in run goes at once;
	// status and pins come straight from the state register.
	assign o_cfg_rdata       = st_r.rdata;
	assign o_bus_grant       = i_bus_req && (st_r.state == ST_RUN);
	assign o_clkrun_n        = 1'b0;
	assign o_clkrun_oe       = st_r.drive_low;
	assign o_bus_clock_out_a = st_r.clk_a;
	assign o_bus_clock_out_b = st_r.clk_b;
	assign o_clocks_stopped  = (st_r.state == ST_STOPPED);
endmodule
`default_nettype wire

/* logic/clk_gate_pkg.sv */
`default_nettype none
package clk_gate_pkg;
	// register indexes inside the downstream-control region
	localparam logic [7:0] IDX_OUTPUT_ENABLES = 8'h38;
	localparam logic [7:0] IDX_SETTING_LOCKS  = 8'h3B;
	localparam logic [7:0] IDX_STOP_CONTROL   = 8'h3C;
	localparam logic [7:0] IDX_IDLE_DELAY     = 8'h3D;

	// field positions of the output-enable register
	localparam int POS_PIN1_STOPPABLE = 3;
	localparam int POS_PIN0_STOPPABLE = 2;
	localparam int POS_PIN1_OUT_EN    = 1;
	localparam int POS_PIN0_OUT_EN    = 0;

	// field positions of the lock register
	localparam int POS_STOP_FEATURE_LOCK = 4;
	localparam int POS_PIN1_STOP_LOCK    = 3;
	localparam int POS_PIN0_STOP_LOCK    = 2;
	localparam int POS_PIN1_OUT_LOCK     = 1;
	localparam int POS_PIN0_OUT_LOCK     = 0;

	// field positions of control and idle-delay registers
	localparam int POS_STOP_FEATURE_EN = 0;
	localparam int POS_IDLE_LSB        = 2;
	localparam int IDLE_FIELD_W        = 6;

	// values after reset
	localparam logic [3:0] RST_OUTPUT_ENABLES = 4'h3;
	localparam logic [4:0] RST_SETTING_LOCKS  = 5'h00;
	localparam logic       RST_STOP_FEATURE   = 1'b0;
	localparam logic [5:0] RST_IDLE_FIELD     = 6'h00;

	// idle delay in bus clocks: base plus step per field unit
	localparam int          IDLE_CNT_W      = 9;
	localparam logic [8:0]  IDLE_BASE_CLKS  = 9'h004;
	localparam logic [8:0]  IDLE_STEP_CLKS  = 9'h004;

	// clock-stop sequencer states
	typedef enum logic [1:0] {
		ST_RUN       = 2'b00,
		ST_IDLE_WAIT = 2'b01,
		ST_STOPPED   = 2'b10,
		ST_RESTART   = 2'b11
	} stop_state_t;
endpackage
`default_nettype wire

/* logic/idle_delay_timer.sv */
`timescale 1ns/1ps
`default_nettype none
// counts bus clocks down from a loaded figure and flags expiry
module idle_delay_timer
	import clk_gate_pkg::*;
(
	input  wire logic                  i_ref_clk,  // system clock
	input  wire logic                  i_sys_rst,  // async reset, high
	input  wire logic                  i_clk_en,   // freezes state when low
	input  wire logic                  i_tick,     // one bus clock elapsed
	input  wire logic                  i_start,    // load and begin counting
	input  wire logic                  i_abort,    // drop the count
	input  wire logic [IDLE_CNT_W-1:0] i_load,     // clocks to wait
	output logic                       o_done      // count expired, level
);
	typedef struct packed {
		logic [IDLE_CNT_W-1:0] cnt;   // remaining clocks
		logic                  busy;  // counting in progress
		logic                  done;  // expiry reached
	} timer_t;

	timer_t st_r;   // registered state
	timer_t st_nxt; // next state

	// load, count down on each bus clock, flag at zero
	always_comb
	begin
		st_nxt = st_r;
		if (i_abort)
		begin
			st_nxt.busy = 1'b0;
			st_nxt.done = 1'b0;
		end
		else if (i_start)
		begin
			st_nxt.cnt  = i_load;
			st_nxt.busy = 1'b1;
			st_nxt.done = 1'b0;
		end
		else if (st_r.busy && i_tick)
		begin
			// last clock of the wait
			if (st_r.cnt <= 9'h001)
			begin
				st_nxt.busy = 1'b0;
				st_nxt.done = 1'b1;
			end
			else
				st_nxt.cnt = st_r.cnt - 9'h001;
		end
	end

	// state register
	always_ff @(posedge i_ref_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			st_r <= '0;
		else if (i_clk_en)
			st_r <= st_nxt;
	end

	assign o_done = st_r.done;
endmodule
`default_nettype wire

/* sim/lpc_clock_output_gating_chk.sv */
`timescale 1ns/1ps
`default_nettype none
// watches the stop sequencer and the register port
module lpc_clock_output_gating_chk
(
	input wire logic       i_ref_clk,         // clock
	input wire logic       i_sys_rst,         // reset
	input wire logic       i_clk_en,          // run enable
	input wire logic       i_cfg_sel,         // portal select
	input wire logic [7:0] i_cfg_index,       // index
	input wire logic       i_cfg_wr,          // write
	input wire logic       i_cfg_rd,          // read
	input wire logic [7:0] i_cfg_wdata,       // write data
	input wire logic [7:0] o_cfg_rdata,       // read data
	input wire logic       i_bus_req,         // request
	input wire logic       o_bus_grant,       // grant
	input wire logic       i_clkrun_n,        // line level
	input wire logic       o_clkrun_n,        // drive value
	input wire logic       o_clkrun_oe,       // drive enable
	input wire logic       o_bus_clock_out_a, // pin a
	input wire logic       o_bus_clock_out_b, // pin b
	input wire logic       o_clocks_stopped   // stopped
);
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_sys_rst);
	// restart pulse ends back in run within one to three system clocks
	sequence s_restart;
		o_clkrun_oe ##[1:3] (!o_clkrun_oe && !o_clocks_stopped);
	endsequence
	property p_drive_low; o_clkrun_n == 1'b0; endproperty
	property p_grant_run; o_bus_grant |-> i_bus_req && !o_clocks_stopped && !o_clkrun_oe; endproperty
	property p_oe_cause; $rose(o_clkrun_oe) |-> $past(o_clocks_stopped && i_bus_req); endproperty
	property p_oe_drop; $rose(o_clkrun_oe) |-> s_restart; endproperty
	property p_grant_after; $fell(o_clkrun_oe) && i_bus_req |-> o_bus_grant; endproperty
	// line must have been released one and nine clocks before the stop, with no request pending
	property p_idle_wait;
		$rose(o_clocks_stopped) |-> $past(i_clkrun_n, 9) && $past(i_clkrun_n) && !$past(i_bus_req);
	endproperty
	property p_req_wakes; o_clocks_stopped && i_bus_req && i_clk_en |=> !o_clocks_stopped && o_clkrun_oe; endproperty
	property p_line_wakes; o_clocks_stopped && !i_clkrun_n |-> ##[1:5] !o_clocks_stopped; endproperty
	property p_rdata_hold; !$past(i_cfg_rd) |-> $stable(o_cfg_rdata); endproperty
	a_drive_low: assert property (p_drive_low) else $error("drive value not low");
	a_grant_run: assert property (p_grant_run) else $error("grant outside run");
	a_oe_cause: assert property (p_oe_cause) else $error("line pulled without request");
	a_oe_drop: assert property (p_oe_drop) else $error("restart too long");
	a_grant_after: assert property (p_grant_after) else $error("no grant after restart");
	a_idle_wait: assert property (p_idle_wait) else $error("stopped too early");
	a_req_wakes: assert property (p_req_wakes) else $error("request did not restart");
	a_line_wakes: assert property (p_line_wakes) else $error("line low did not restart");
	a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
endmodule
bind lpc_clock_output_gating lpc_clock_output_gating_chk lpc_clock_output_gating_chk_inst (.*);
`default_nettype wire

/* sim/clkrun_peer_model.sv */
`timescale 1ns/1ps
`default_nettype none
// peripheral on the shared clock-run line, open drain with pull-up
module clkrun_peer_model
(
	input  wire logic i_want,    // peripheral asks for clocks
	input  wire logic i_dev_oe,  // device pulls the line
	input  wire logic i_dev_val, // device drive value
	output logic      o_line     // resolved line level
);
	// pull-up wins unless a party drives low
	assign o_line = !((i_dev_oe && !i_dev_val) || i_want);
endmodule
`default_nettype wire

/* sim/lpc_clock_output_gating_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module lpc_clock_output_gating_bench;
	import clk_gate_pkg::*;
	logic i_ref_clk = 1'b0, i_sys_rst = 1'b1, i_clk_en = 1'b1, i_cfg_sel = 1'b1;
	logic i_cfg_wr = 1'b0, i_cfg_rd = 1'b0, i_bus_req = 1'b0, want = 1'b0;
	logic [7:0] i_cfg_index = 8'h00, i_cfg_wdata = 8'h00, o_cfg_rdata;
	logic o_bus_grant, i_clkrun_n, o_clkrun_n, o_clkrun_oe;
	logic o_bus_clock_out_a, o_bus_clock_out_b, o_clocks_stopped;
	int num_errors = 0;
	int compares = 0;
	always #10 i_ref_clk = ~i_ref_clk;
	lpc_clock_output_gating lpc_clock_output_gating_inst (.*);
	clkrun_peer_model clkrun_peer_model_inst (.i_want(want), .i_dev_oe(o_clkrun_oe),
		.i_dev_val(o_clkrun_n), .o_line(i_clkrun_n));
	task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
		compares++;
		if (got !== exp)
		begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		@(negedge i_ref_clk);
		i_cfg_index = idx;
		i_cfg_wdata = d;
		i_cfg_wr = 1'b1;
		@(negedge i_ref_clk);
		i_cfg_wr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
		@(negedge i_ref_clk);
		i_cfg_index = idx;
		i_cfg_rd = 1'b1;
		@(negedge i_ref_clk);
		i_cfg_rd = 1'b0;
		check("rdata", exp, o_cfg_rdata);
	endtask
	// counts level changes on both pins over a short span
	task automatic pins(input logic ra, input logic rb);
		int na, nb;
		logic pa, pb;
		na = 0;
		nb = 0;
		pa = o_bus_clock_out_a;
		pb = o_bus_clock_out_b;
		repeat (16)
		begin
			@(negedge i_ref_clk);
			na += int'(o_bus_clock_out_a !== pa);
			nb += int'(o_bus_clock_out_b !== pb);
			pa = o_bus_clock_out_a;
			pb = o_bus_clock_out_b;
		end
		check("pin a running", {7'h00, ra}, {7'h00, na > 0});
		check("pin b running", {7'h00, rb}, {7'h00, nb > 0});
	endtask
	// peripheral pulses the line, then cycles until stop are counted
	task automatic stop_after(output int n);
		n = 0;
		want = 1'b1;
		repeat (4) @(negedge i_ref_clk);
		want = 1'b0;
		while (o_clocks_stopped !== 1'b1 && n < 200)
		begin
			@(negedge i_ref_clk);
			n++;
		end
	endtask
	task automatic wake_by_req();
		int k;
		i_bus_req = 1'b1;
		for (k = 0; k < 8 && o_bus_grant !== 1'b1; k++) @(negedge i_ref_clk);
		check("grant", 8'h01, {7'h00, o_bus_grant});
		i_bus_req = 1'b0;
	endtask
	task automatic reset_dut();
		i_sys_rst = 1'b1;
		repeat (12) @(negedge i_ref_clk);
		i_sys_rst = 1'b0;
	endtask
	task automatic test_done();
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// main sequence of register and clock-stop checks
	initial
	begin
		int n0, n1;
		logic [4:0] lk;
		reset_dut();
		rd(IDX_OUTPUT_ENABLES, 8'h03);
		rd(IDX_SETTING_LOCKS, 8'h00);
		rd(IDX_STOP_CONTROL, 8'h00);
		rd(8'h39, 8'h00);
		wr(IDX_IDLE_DELAY, 8'hFF);
		rd(IDX_IDLE_DELAY, 8'hFC);
		i_cfg_sel = 1'b0;
		rd(IDX_IDLE_DELAY, 8'h00);
		i_cfg_sel = 1'b1;
		wr(IDX_IDLE_DELAY, 8'h00);
		wr(IDX_OUTPUT_ENABLES, 8'hFE);
		rd(IDX_OUTPUT_ENABLES, 8'h0E);
		pins(1'b0, 1'b1);
		wr(IDX_OUTPUT_ENABLES, 8'h0D);
		pins(1'b1, 1'b0);
		wr(IDX_OUTPUT_ENABLES, 8'h07);
		stop_after(n0);
		check("stopped", 8'h00, {7'h00, o_clocks_stopped});
		wr(IDX_STOP_CONTROL, 8'hFF);
		rd(IDX_STOP_CONTROL, 8'h01);
		stop_after(n0);
		check("wait low", 8'h01, {7'h00, n0 >= 2 * IDLE_BASE_CLKS});
		check("wait high", 8'h01, {7'h00, n0 <= 2 * IDLE_BASE_CLKS + 6});
		pins(1'b0, 1'b1);
		wake_by_req();
		pins(1'b1, 1'b1);
		wr(IDX_IDLE_DELAY, 8'h04);
		stop_after(n1);
		want = 1'b1;
		repeat (6) @(negedge i_ref_clk);
		check("line wake", 8'h00, {7'h00, o_clocks_stopped});
		stop_after(n1);
		check("step", 8'h01, {7'h00, n1 - n0 >= 2 * IDLE_STEP_CLKS - 2 &&
			n1 - n0 <= 2 * IDLE_STEP_CLKS + 2});
		wake_by_req();
		wr(IDX_OUTPUT_ENABLES, 8'h0B);
		stop_after(n0);
		pins(1'b1, 1'b0);
		wake_by_req();
		wr(IDX_OUTPUT_ENABLES, 8'h03);
		stop_after(n0);
		check("stopped", 8'h01, {7'h00, o_clocks_stopped});
		pins(1'b1, 1'b1);
		wake_by_req();
		// each lock alone, after a fresh reset
		for (int i = 0; i < 5; i++)
		begin
			lk = 5'h01 << i;
			reset_dut();
			wr(IDX_SETTING_LOCKS, {3'h0, lk});
			wr(IDX_OUTPUT_ENABLES, 8'h0C);
			wr(IDX_STOP_CONTROL, 8'h01);
			wr(IDX_SETTING_LOCKS, 8'h00);
			rd(IDX_SETTING_LOCKS, {3'h0, lk});
			rd(IDX_OUTPUT_ENABLES, {4'h0, ~lk[3], ~lk[2], lk[1], lk[0]});
			rd(IDX_STOP_CONTROL, {7'h00, ~lk[4]});
		end
		// frozen cycles take no write
		i_clk_en = 1'b0;
		wr(IDX_IDLE_DELAY, 8'h08);
		i_clk_en = 1'b1;
		rd(IDX_IDLE_DELAY, 8'h00);
		test_done();
	end
	// cuts a hang short
	initial
	begin
		#400000;
		num_errors++;
		$display("mismatch watchdog expected done seen timeout");
		test_done();
	end
endmodule
`default_nettype wire
